/* File: design/spi_access_pkg.sv */
// Package with constants for the serial status and strobe access block.
package spi_access_pkg;
   localparam int HDR_RW_BIT = 7;
   localparam int HDR_BURST_BIT = 6;
   localparam logic [5:0] CFG_LAST_ADDR = 6'h2E;
   localparam logic [5:0] STROBE_FIRST_ADDR = 6'h30;
   localparam logic [5:0] STROBE_LAST_ADDR = 6'h3D;
   localparam logic [5:0] CHIP_RESET_ADDR = 6'h30;
   localparam logic [5:0] CRYSTAL_OFF_ADDR = 6'h32;
   localparam logic [5:0] POWER_DOWN_ADDR = 6'h39;
   localparam logic [5:0] FLUSH_RECEIVE_ADDR = 6'h3A;
   localparam logic [5:0] FLUSH_TRANSMIT_ADDR = 6'h3B;
   localparam int CFG_COUNT = 47;
   localparam logic [7:0] CFG_RESET_VALUE = 8'h00;
   localparam logic [3:0] COUNT_SATURATE = 4'hF;
   localparam int BITS_PER_BYTE = 8;
   typedef enum logic [2:0] {
      IDLE_STATE = 3'h0,
      RECEIVE_STATE = 3'h1,
      TRANSMIT_STATE = 3'h2,
      FAST_TRANSMIT_READY_STATE = 3'h3,
      CALIBRATE_STATE = 3'h4,
      SETTLING_STATE = 3'h5,
      RECEIVE_OVERFLOW_STATE = 3'h6,
      TRANSMIT_UNDERFLOW_STATE = 3'h7
   } main_state_t;
endpackage : spi_access_pkg

/* File: design/status_byte_build.sv */
// Status byte assembly with saturating FIFO count.
`timescale 1ns/1ps
`default_nettype none
module status_byte_build
   import spi_access_pkg::*;
(
   input wire logic crystal_not_ready_flag,
   input wire logic [2:0] state_code,
   input wire logic transitional,
   input wire logic read_flag,
   input wire logic [6:0] rx_count,
   input wire logic [6:0] tx_free,
   output logic [7:0] status_byte
);
   logic [6:0] cnt;
   always_comb begin
      cnt = read_flag ? rx_count : tx_free;
      status_byte[7] = crystal_not_ready_flag;
      // Settling and calibration may show as idle while the sequencer moves.
      status_byte[6:4] = (transitional && (state_code == 3'h4 || state_code == 3'h5)) ?
                         3'h0 : state_code;
      status_byte[3:0] = (cnt > 7'(COUNT_SATURATE)) ? COUNT_SATURATE : cnt[3:0];
   end
endmodule : status_byte_build
`default_nettype wire

/* File: design/spi_access.sv */
// Serial slave front end: header decode, register file, strobes, status.
`timescale 1ns/1ps
`default_nettype none
module spi_access
   import spi_access_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RSTN,
   input wire logic SCLK,
   input wire logic CS_N,
   input wire logic SI,
   output logic SO,
   output logic SO_OE_N,
   input wire logic CRYSTAL_STABLE,
   input wire logic [2:0] MAIN_STATE,
   input wire logic TRANSITIONAL,
   input wire logic [6:0] RX_COUNT,
   input wire logic [6:0] TX_FREE,
   input wire logic [7:0] STATUS_REG_DATA,
   output logic [5:0] STATUS_REG_ADDR,
   output logic [5:0] STROBE_ADDR,
   output logic STROBE_PULSE,
   output logic CORE_POWERED,
   output logic OTHERS_POWERED
);
   typedef struct packed {
      logic [2:0] sclk_s;
      logic [1:0] cs_s;
      logic [1:0] si_s;
      logic active;
      logic [2:0] bitc;
      logic [7:0] sh_in;
      logic [7:0] sh_out;
      logic hdr_done;
      logic rd;
      logic burst;
      logic [5:0] addr;
      logic [5:0] pend_strobe;
      logic pend_valid;
      logic [5:0] strobe_addr;
      logic strobe_pulse;
      logic so;
      logic so_oe_n;
   } state_t;
   state_t q, d;
   logic [7:0] cfg_q [CFG_COUNT];
   logic cfg_we;
   logic [5:0] cfg_wa;
   logic [7:0] cfg_wd;
   logic [7:0] status_byte;
   logic rst_n;
   logic [1:0] rst_sync_q;
   logic rise;
   logic fall;
   logic [7:0] byte_in;
   logic [7:0] rd_byte;
   logic [5:0] haddr;

   assign rst_n = rst_sync_q[1];
   // Before the header is in, the first bit the master sets up is the read flag.
   // The count bits leave the shifter only after the first clock, so they can follow it.
   status_byte_build u_status (
      .crystal_not_ready_flag(~CRYSTAL_STABLE),
      .state_code(MAIN_STATE),
      .transitional(TRANSITIONAL),
      .read_flag(q.hdr_done ? q.rd : q.si_s[1]),
      .rx_count(RX_COUNT),
      .tx_free(TX_FREE),
      .status_byte(status_byte)
   );

   always_comb begin
      d = q;
      d.sclk_s = {q.sclk_s[1:0], SCLK};
      d.cs_s = {q.cs_s[0], CS_N};
      d.si_s = {q.si_s[0], SI};
      d.strobe_pulse = 1'b0;
      cfg_we = 1'b0;
      cfg_wa = q.addr;
      cfg_wd = 8'h00;
      rise = q.sclk_s[1] && !q.sclk_s[2];
      fall = !q.sclk_s[1] && q.sclk_s[2];
      byte_in = {q.sh_in[6:0], q.si_s[1]};
      haddr = byte_in[5:0];
      rd_byte = (q.addr <= CFG_LAST_ADDR) ? cfg_q[q.addr] : 8'h00;
      if (q.cs_s[1]) begin
         // Select high ends any burst and cancels a partial byte.
         d.active = 1'b0;
         d.hdr_done = 1'b0;
         d.bitc = 3'h0;
         d.so_oe_n = 1'b1;
         if (q.pend_valid) begin
            d.strobe_addr = q.pend_strobe;
            d.strobe_pulse = 1'b1;
            d.pend_valid = 1'b0;
         end
      end else begin
         d.so_oe_n = 1'b0;
         if (!q.active) begin
            d.active = 1'b1;
            d.sh_out = {status_byte[6:0], 1'b0};
            d.so = status_byte[7];
         end
         if (!q.hdr_done && q.bitc == 3'h0) begin
            // Keep the ready flag live while the master waits for it.
            // Bit 7 already stands on the pin, so the shifter holds the bits after it.
            d.so = status_byte[7];
            d.sh_out = {status_byte[6:0], 1'b0};
         end
         if (rise) begin
            d.sh_in = byte_in;
            d.bitc = q.bitc + 3'h1;
            if (q.bitc == 3'(BITS_PER_BYTE - 1)) begin
               if (!q.hdr_done) begin
                  d.rd = byte_in[HDR_RW_BIT];
                  d.burst = byte_in[HDR_BURST_BIT];
                  d.addr = haddr;
                  d.hdr_done = 1'b1;
                  if (haddr >= STROBE_FIRST_ADDR && haddr <= STROBE_LAST_ADDR
                      && !byte_in[HDR_BURST_BIT]) begin
                     d.hdr_done = 1'b0;
                     if (haddr == POWER_DOWN_ADDR || haddr == CRYSTAL_OFF_ADDR) begin
                        d.pend_strobe = haddr;
                        d.pend_valid = 1'b1;
                     end else begin
                        d.strobe_addr = haddr;
                        d.strobe_pulse = 1'b1;
                     end
                  end
               end else begin
                  if (!q.rd && q.addr <= CFG_LAST_ADDR) begin
                     cfg_we = 1'b1;
                     cfg_wd = byte_in;
                  end
                  if (q.burst && q.addr <= CFG_LAST_ADDR) begin
                     d.addr = q.addr + 6'h01;
                  end else begin
                     d.hdr_done = 1'b0;
                  end
               end
            end
         end
         if (fall) begin
            if (q.bitc == 3'h0 && q.hdr_done && q.rd) begin
               // Read data replaces status after the header.
               if (q.addr >= STROBE_FIRST_ADDR && q.burst) begin
                  d.sh_out = {STATUS_REG_DATA[6:0], 1'b0};
                  d.so = STATUS_REG_DATA[7];
               end else begin
                  d.sh_out = {rd_byte[6:0], 1'b0};
                  d.so = rd_byte[7];
               end
            end else if (q.bitc == 3'h0) begin
               d.sh_out = {status_byte[6:0], 1'b0};
               d.so = status_byte[7];
            end else begin
               d.so = q.sh_out[7];
               d.sh_out = {q.sh_out[6:0], 1'b0};
            end
         end
      end
   end

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end

   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         q.sclk_s <= 3'h0;
         q.cs_s <= 2'b11;
         q.si_s <= 2'b00;
         q.active <= 1'b0;
         q.bitc <= 3'h0;
         q.sh_in <= 8'h00;
         q.sh_out <= 8'h00;
         q.hdr_done <= 1'b0;
         q.rd <= 1'b0;
         q.burst <= 1'b0;
         q.addr <= 6'h00;
         q.pend_strobe <= 6'h00;
         q.pend_valid <= 1'b0;
         q.strobe_addr <= 6'h00;
         q.strobe_pulse <= 1'b0;
         q.so <= 1'b1;
         q.so_oe_n <= 1'b1;
      end else begin
         q.sclk_s <= d.sclk_s;
         q.cs_s <= d.cs_s;
         q.si_s <= d.si_s;
         q.active <= d.active;
         q.bitc <= d.bitc;
         q.sh_in <= d.sh_in;
         q.sh_out <= d.sh_out;
         q.hdr_done <= d.hdr_done;
         q.rd <= d.rd;
         q.burst <= d.burst;
         q.addr <= d.addr;
         q.pend_strobe <= d.pend_strobe;
         q.pend_valid <= d.pend_valid;
         q.strobe_addr <= d.strobe_addr;
         q.strobe_pulse <= d.strobe_pulse;
         q.so <= d.so;
         q.so_oe_n <= d.so_oe_n;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < CFG_COUNT; gi++) begin : g_cfg
         always_ff @(posedge REF_CLK or negedge rst_n) begin
            if (!rst_n) begin
               cfg_q[gi] <= CFG_RESET_VALUE;
            end else if (cfg_we && cfg_wa == 6'(gi)) begin
               cfg_q[gi] <= cfg_wd;
            end
         end
      end
   endgenerate

   assign SO = q.so;
   assign SO_OE_N = q.so_oe_n;
   assign STROBE_ADDR = q.strobe_addr;
   assign STROBE_PULSE = q.strobe_pulse;
   assign STATUS_REG_ADDR = q.addr;
   // Idle leaves only crystal and core on.
   assign CORE_POWERED = 1'b1;
   assign OTHERS_POWERED = (MAIN_STATE != IDLE_STATE);

   // A deferred strobe is released in two steps: select seen high, then one pulse.
   sequence deferred_strobe_release;
      q.pend_valid && q.cs_s[1];
   endsequence
   sequence strobe_issued_once;
      q.strobe_pulse && !q.pend_valid;
   endsequence

   chk_pending_strobe_fires: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      deferred_strobe_release |=> strobe_issued_once)
      else $error("deferred strobe not issued at select high");
   chk_select_cancels: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      q.cs_s[1] |=> (!q.hdr_done && q.bitc == 3'h0))
      else $error("select high did not cancel transfer");
   chk_idle_powers_off: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      (MAIN_STATE == IDLE_STATE) |-> (!OTHERS_POWERED && CORE_POWERED))
      else $error("modules powered in idle");
   chk_status_ready_bit: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      (!q.cs_s[1] && !q.hdr_done && q.bitc == 3'h0) |=> (SO != $past(CRYSTAL_STABLE)))
      else $error("ready flag wrong on serial output");
   chk_count_saturates: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      (RX_COUNT > 7'h0F && q.hdr_done && q.rd) |-> status_byte[3:0] == 4'hF)
      else $error("count not saturated");
   chk_burst_advance: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      (q.hdr_done && q.burst && rise && q.bitc == 3'h7 && !q.cs_s[1]
       && q.addr <= CFG_LAST_ADDR) |=> q.addr == $past(q.addr) + 6'h01)
      else $error("burst address did not advance");
   chk_strobe_single: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      q.strobe_pulse |=> !q.strobe_pulse)
      else $error("strobe pulse longer than one cycle");
   chk_so_drive: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      q.cs_s[1] |=> SO_OE_N)
      else $error("output driven while deselected");
endmodule : spi_access
`default_nettype wire

/* File: verif/spi_host_model.sv */
// Host master model that drives the serial link pins.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   input wire logic clk,
   input wire logic so,
   output logic sclk,
   output logic cs_n,
   output logic si
);
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #5;
   endtask : tick
   // Bounded wait, so a device that never gets ready cannot hang the run.
   task automatic wait_ready();
      for (int i = 0; i < 50 && so !== 1'h0; i++) tick(1);
   endtask : wait_ready
   task automatic start();
      cs_n = 1'h0;
      tick(6);
      wait_ready();
   endtask : start
   // The link clock stands still outside frames; the data line is inverted when released.
   task automatic stop();
      tick(4);
      cs_n = 1'h1;
      si = ~si;
      tick(8);
   endtask : stop
   task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         si = tx[i];
         tick(4);
         sclk = 1'h1;
         rx[i] = so;
         tick(4);
         sclk = 1'h0;
      end
   endtask : xfer
   initial begin
      sclk = 1'h0;
      cs_n = 1'h1;
      si = 1'h0;
   end
endmodule : spi_host_model
`default_nettype wire

/* File: verif/spi_access_tb.sv */
// Self-checking bench for the serial status and strobe access block.
`timescale 1ns/1ps
`default_nettype none
module spi_access_tb;
   import spi_access_pkg::*;
   logic clk, rstn, sclk, cs_n, si, so, so_oe_n, stable, trans, pulse, core_on, others_on;
   logic [2:0] state;
   logic [6:0] rxc, txf;
   logic [7:0] sreg, rx;
   logic [5:0] sraddr, saddr, last_strobe;
   int error_cnt, checks_done, pulses;
   spi_access uut (.REF_CLK(clk), .RSTN(rstn), .SCLK(sclk), .CS_N(cs_n), .SI(si), .SO(so),
      .SO_OE_N(so_oe_n), .CRYSTAL_STABLE(stable), .MAIN_STATE(state), .TRANSITIONAL(trans),
      .RX_COUNT(rxc), .TX_FREE(txf), .STATUS_REG_DATA(sreg), .STATUS_REG_ADDR(sraddr),
      .STROBE_ADDR(saddr), .STROBE_PULSE(pulse), .CORE_POWERED(core_on),
      .OTHERS_POWERED(others_on));
   spi_host_model h (.clk(clk), .so(so), .sclk(sclk), .cs_n(cs_n), .si(si));
   always #50 clk = ~clk;
   always @(posedge clk) if (pulse === 1'h1) begin
      pulses++;
      last_strobe <= saddr;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   function automatic logic [7:0] status(input logic rd);
      logic [2:0] code;
      logic [6:0] cnt;
      code = (trans && (state == 3'h4 || state == 3'h5)) ? 3'h0 : state;
      cnt = rd ? rxc : txf;
      return {~stable, code, (cnt > 7'h0F) ? 4'hF : cnt[3:0]};
   endfunction : status
   task automatic access(input logic [7:0] hdr, input logic [7:0] dat, input int n,
      output logic [7:0] got);
      h.start();
      h.xfer(hdr, 8, got);
      check(got, status(hdr[7]));
      if (n > 0) h.xfer(dat, n, got);
      h.stop();
   endtask : access
   task automatic print_verdict();
      $display("errors %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict
   initial begin
      #2ms;
      error_cnt++;
      print_verdict();
   end
   initial begin
      clk = 1'h0;
      rstn = 1'h0;
      stable = 1'h0;
      trans = 1'h0;
      state = 3'h0;
      rxc = 7'h00;
      txf = 7'h00;
      sreg = 8'h5A;
      repeat (8) @(posedge clk);
      #5 rstn = 1'h1;
      h.tick(4);
      // Without a running crystal the selected device must keep its output high.
      h.cs_n = 1'h0;
      h.tick(10);
      check(8'(so), 8'h01);
      check(8'(so_oe_n), 8'h00);
      stable = 1'h1;
      h.wait_ready();
      check(8'(so), 8'h00);
      h.stop();
      check(8'(core_on), 8'h01);
      for (int s = 0; s < 8; s++) begin
         state = s[2:0];
         trans = (s == 4);
         txf = 7'(s * 3);
         rxc = 7'(20 - s * 2);
         access({2'h0, 6'(s)}, 8'(s) ^ 8'hA5, 8, rx);
         check(rx, status(1'h0));
         access({2'h2, 6'(s)}, 8'h00, 8, rx);
         check(rx, 8'(s) ^ 8'hA5);
         check(8'(others_on), 8'(s != 0));
      end
      // The burst rewrite of configuration below happens while idle is reported.
      state = 3'h0;
      trans = 1'h0;
      h.start();
      h.xfer(8'h6D, 8, rx);
      h.xfer(8'h11, 8, rx);
      h.xfer(8'h22, 8, rx);
      h.stop();
      h.start();
      h.xfer(8'hED, 8, rx);
      h.xfer(8'h00, 8, rx);
      check(rx, 8'h11);
      h.xfer(8'h00, 8, rx);
      check(rx, 8'h22);
      h.stop();
      // A write cut short by the select line must leave the register alone.
      access(8'h03, 8'hFF, 4, rx);
      access(8'h83, 8'h00, 8, rx);
      check(rx, 8'hA6);
      pulses = 0;
      h.start();
      h.xfer(8'h3A, 8, rx);
      h.tick(4);
      check(8'(pulses), 8'h01);
      check(8'(last_strobe), 8'h3A);
      h.xfer(8'hB9, 8, rx);
      check(rx, status(1'h1));
      h.tick(8);
      check(8'(pulses), 8'h01);
      h.stop();
      check(8'(pulses), 8'h02);
      check(8'(last_strobe), 8'h39);
      access(8'hF5, 8'h00, 8, rx);
      check(rx, 8'h5A);
      check(8'(sraddr), 8'h35);
      check(8'(pulses), 8'h02);
      h.start();
      h.xfer(8'h30, 8, rx);
      h.wait_ready();
      h.xfer(8'h80, 8, rx);
      check(rx, status(1'h1));
      h.stop();
      print_verdict();
   end
endmodule : spi_access_tb
`default_nettype wire
